// ==== hdl/fgp_pkg.sv ====
// Purpose: Constants for the fast port register block
// Assumes: One bus clock, 32 pins per port, word-aligned register offsets
// Notes: Offsets are byte addresses within one port's register window
package fgp_pkg;
   localparam int FGP_WIDTH = 32;
   localparam int FGP_ADDR_W = 6;
   localparam logic [FGP_ADDR_W-1:0] FGP_OFS_OUT = 6'h00;
   localparam logic [FGP_ADDR_W-1:0] FGP_OFS_SET = 6'h04;
   localparam logic [FGP_ADDR_W-1:0] FGP_OFS_CLR = 6'h08;
   localparam logic [FGP_ADDR_W-1:0] FGP_OFS_TGL = 6'h0c;
   localparam logic [FGP_ADDR_W-1:0] FGP_OFS_IN = 6'h10;
   localparam logic [FGP_ADDR_W-1:0] FGP_OFS_DIR = 6'h14;
   localparam logic [FGP_WIDTH-1:0] FGP_RST_VAL = 32'h0000_0000;
   localparam logic [FGP_WIDTH-1:0] FGP_IMPL_DEF = 32'hffff_ffff;
   localparam logic [31:0] FGP_LOCAL_BASE = 32'hf800_0000;
   localparam int FGP_ERR_WAIT = 1;
   typedef enum logic [1:0] {
      FGP_SYS_IDLE = 2'b00,
      FGP_SYS_ERR = 2'b01
   } fgp_sys_e;
endpackage : fgp_pkg

// ==== hdl/fgp_port.sv ====
// Purpose: Fast port registers with a single-cycle local port and a system bus port
// Assumes: Pin inputs are asynchronous; local port has priority over system bus
// Notes: Local port never waits; system bus stalls on collision or in compute-only state
`timescale 1ns/1ns
module fgp_port
   import fgp_pkg::*;
#(
   parameter logic [FGP_WIDTH-1:0] IMPL_MASK = FGP_IMPL_DEF
) (
   input wire logic clk,
   input wire logic rst,
   // Processor-local port, offset already stripped from the alias window
   input wire logic lcl_sel,
   input wire logic lcl_wr,
   input wire logic [FGP_ADDR_W-1:0] lcl_addr,
   input wire logic [FGP_WIDTH-1:0] lcl_wdata,
   output logic [FGP_WIDTH-1:0] lcl_rdata,
   output logic lcl_err,
   // System bus (DMA) port
   input wire logic sys_sel,
   input wire logic sys_wr,
   input wire logic [FGP_ADDR_W-1:0] sys_addr,
   input wire logic [FGP_WIDTH-1:0] sys_wdata,
   output logic [FGP_WIDTH-1:0] sys_rdata,
   output logic sys_ready,
   output logic sys_err,
   // Chip state and pin-mux side
   input wire logic compute_only,
   input wire logic pctl_enable,
   input wire logic [FGP_WIDTH-1:0] pin_digital,
   input wire logic [FGP_WIDTH-1:0] pin_gpio,
   input wire logic [FGP_WIDTH-1:0] pin_in,
   output logic [FGP_WIDTH-1:0] pin_out,
   output logic [FGP_WIDTH-1:0] pin_oe_n,
   output logic [FGP_WIDTH-1:0] output_data_register
);
   logic [FGP_WIDTH-1:0] out_ff;
   logic [FGP_WIDTH-1:0] dir_ff;
   logic [FGP_WIDTH-1:0] in_ff;
   logic [FGP_WIDTH-1:0] sync1_ff;
   logic [FGP_WIDTH-1:0] sync2_ff;
   logic [FGP_WIDTH-1:0] lcl_rdata_ff;
   logic [FGP_WIDTH-1:0] sys_rdata_ff;
   logic lcl_err_ff;
   fgp_sys_e sys_st_ff;
   fgp_sys_e nxt_sys_st;
   logic [FGP_WIDTH-1:0] nxt_out;
   logic [FGP_WIDTH-1:0] nxt_dir;
   logic [FGP_WIDTH-1:0] nxt_in;
   logic [FGP_WIDTH-1:0] nxt_lcl_rdata;
   logic [FGP_WIDTH-1:0] nxt_sys_rdata;
   logic nxt_lcl_err;
   logic [FGP_WIDTH-1:0] oe_bits;

   // Local port register decode
   wire lcl_hit_out = (lcl_addr == FGP_OFS_OUT);
   wire lcl_hit_set = (lcl_addr == FGP_OFS_SET);
   wire lcl_hit_clr = (lcl_addr == FGP_OFS_CLR);
   wire lcl_hit_tgl = (lcl_addr == FGP_OFS_TGL);
   wire lcl_hit_in = (lcl_addr == FGP_OFS_IN);
   wire lcl_hit_dir = (lcl_addr == FGP_OFS_DIR);
   wire lcl_hit_wo = lcl_hit_set || lcl_hit_clr || lcl_hit_tgl;
   wire lcl_hit_rw = lcl_hit_out || lcl_hit_in || lcl_hit_dir;
   wire lcl_mapped = lcl_hit_wo || lcl_hit_rw;

   // System bus register decode
   wire sys_hit_out = (sys_addr == FGP_OFS_OUT);
   wire sys_hit_set = (sys_addr == FGP_OFS_SET);
   wire sys_hit_clr = (sys_addr == FGP_OFS_CLR);
   wire sys_hit_tgl = (sys_addr == FGP_OFS_TGL);
   wire sys_hit_in = (sys_addr == FGP_OFS_IN);
   wire sys_hit_dir = (sys_addr == FGP_OFS_DIR);
   wire sys_hit_wo = sys_hit_set || sys_hit_clr || sys_hit_tgl;
   wire sys_hit_rw = sys_hit_out || sys_hit_in || sys_hit_dir;
   wire sys_mapped = sys_hit_wo || sys_hit_rw;

   // Local port always wins; system bus blocked on collision or compute-only
   wire lcl_ok = lcl_sel && lcl_mapped;
   wire lcl_bad = lcl_sel && !lcl_mapped;
   wire sys_blocked = lcl_sel || compute_only;
   wire sys_stall = sys_sel && sys_blocked;
   wire sys_idle = (sys_st_ff == FGP_SYS_IDLE);
   wire sys_in_err = (sys_st_ff == FGP_SYS_ERR);
   wire sys_go = sys_sel && !sys_blocked && sys_idle;
   wire sys_ok = sys_go && sys_mapped;
   wire sys_bad = sys_go && !sys_mapped;

   // Write strobes of the winning port, one writer per cycle
   wire lcl_wr_ok = lcl_ok && lcl_wr;
   wire sys_wr_ok = sys_ok && sys_wr;
   wire wr_out = (lcl_wr_ok && lcl_hit_out) || (sys_wr_ok && sys_hit_out);
   wire wr_set = (lcl_wr_ok && lcl_hit_set) || (sys_wr_ok && sys_hit_set);
   wire wr_clr = (lcl_wr_ok && lcl_hit_clr) || (sys_wr_ok && sys_hit_clr);
   wire wr_tgl = (lcl_wr_ok && lcl_hit_tgl) || (sys_wr_ok && sys_hit_tgl);
   wire wr_dir = (lcl_wr_ok && lcl_hit_dir) || (sys_wr_ok && sys_hit_dir);
   wire [FGP_WIDTH-1:0] wr_src = lcl_ok ? lcl_wdata : sys_wdata;
   // Absent pins never take a one
   wire [FGP_WIDTH-1:0] wr_data = wr_src & IMPL_MASK;

   // Input sampling frozen when port control is off or clocks gated
   wire in_track = pctl_enable && !compute_only;

   // Per-pin logic; writes ignore pctl_enable on purpose
   genvar gi;
   generate
      for (gi = 0; gi < FGP_WIDTH; gi++) begin : g_pin
         wire set_b = wr_set && wr_data[gi];
         wire clr_b = wr_clr && wr_data[gi];
         wire tgl_b = wr_tgl && wr_data[gi];
         wire keep_b = out_ff[gi];
         wire flip_b = ~out_ff[gi];
         wire mod_b = set_b || clr_b || tgl_b;
         wire mod_val_b = set_b ? 1'b1 : (clr_b ? 1'b0 : flip_b);
         wire in_val_b = sync2_ff[gi] && pin_digital[gi] && IMPL_MASK[gi];
         wire drive_b = pin_gpio[gi] && dir_ff[gi] && IMPL_MASK[gi];
         assign nxt_out[gi] = wr_out ? wr_data[gi] : (mod_b ? mod_val_b : keep_b);
         assign nxt_dir[gi] = wr_dir ? wr_data[gi] : dir_ff[gi];
         assign nxt_in[gi] = in_track ? in_val_b : in_ff[gi];
         assign oe_bits[gi] = drive_b;
      end
   endgenerate

   // System bus error takes one extra cycle
   always_comb begin
      case (sys_st_ff)
         FGP_SYS_IDLE: begin
            nxt_sys_st = sys_bad ? FGP_SYS_ERR : FGP_SYS_IDLE;
         end
         FGP_SYS_ERR: begin
            nxt_sys_st = FGP_SYS_IDLE;
         end
         default: begin
            nxt_sys_st = FGP_SYS_IDLE;
         end
      endcase
   end

   // Read muxes; set, clear and toggle read back as zero
   wire [FGP_WIDTH-1:0] lcl_rd_out = lcl_hit_out ? out_ff : FGP_RST_VAL;
   wire [FGP_WIDTH-1:0] lcl_rd_in = lcl_hit_in ? in_ff : FGP_RST_VAL;
   wire [FGP_WIDTH-1:0] lcl_rd_dir = lcl_hit_dir ? dir_ff : FGP_RST_VAL;
   wire [FGP_WIDTH-1:0] lcl_rd_mux = lcl_rd_out | lcl_rd_in | lcl_rd_dir;
   wire [FGP_WIDTH-1:0] sys_rd_out = sys_hit_out ? out_ff : FGP_RST_VAL;
   wire [FGP_WIDTH-1:0] sys_rd_in = sys_hit_in ? in_ff : FGP_RST_VAL;
   wire [FGP_WIDTH-1:0] sys_rd_dir = sys_hit_dir ? dir_ff : FGP_RST_VAL;
   wire [FGP_WIDTH-1:0] sys_rd_mux = sys_rd_out | sys_rd_in | sys_rd_dir;

   assign nxt_lcl_rdata = lcl_ok ? lcl_rd_mux : FGP_RST_VAL;
   assign nxt_sys_rdata = sys_ok ? sys_rd_mux : FGP_RST_VAL;
   assign nxt_lcl_err = lcl_bad;

   // First synchroniser stage for the pins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_ff <= FGP_RST_VAL;
      end else begin
         sync1_ff <= pin_in;
      end
   end

   // Second synchroniser stage for the pins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync2_ff <= FGP_RST_VAL;
      end else begin
         sync2_ff <= sync1_ff;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_ff <= FGP_RST_VAL;
      end else begin
         out_ff <= nxt_out;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dir_ff <= FGP_RST_VAL;
      end else begin
         dir_ff <= nxt_dir;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_ff <= FGP_RST_VAL;
      end else begin
         in_ff <= nxt_in;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sys_st_ff <= FGP_SYS_IDLE;
      end else begin
         sys_st_ff <= nxt_sys_st;
      end
   end

   // Read data registered, valid the cycle after the access
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lcl_rdata_ff <= FGP_RST_VAL;
      end else begin
         lcl_rdata_ff <= nxt_lcl_rdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sys_rdata_ff <= FGP_RST_VAL;
      end else begin
         sys_rdata_ff <= nxt_sys_rdata;
      end
   end

   // Local error shows one cycle late, the local port has no wait state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lcl_err_ff <= 1'b0;
      end else begin
         lcl_err_ff <= nxt_lcl_err;
      end
   end

   assign lcl_rdata = lcl_rdata_ff;
   assign lcl_err = lcl_err_ff;
   assign sys_rdata = sys_rdata_ff;

   // Ready low during stall and in the cycle an unmapped access is decoded; high again in the error state
   assign sys_ready = !sys_stall && !sys_bad;
   assign sys_err = sys_in_err;

   assign output_data_register = out_ff;
   assign pin_out = out_ff;
   assign pin_oe_n = ~oe_bits;
endmodule : fgp_port

// ==== verification/fgp_port_assertions.sv ====
// Purpose: Port timing and data checks
// Assumes: One clock, reset high
// Notes: Bound in the bench top file
`timescale 1ns/1ns
module fgp_port_chk
   import fgp_pkg::*;
#(
   parameter logic [31:0] IMPL_MASK = FGP_IMPL_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic lcl_sel,
   input wire logic lcl_wr,
   input wire logic sys_sel,
   input wire logic sys_ready,
   input wire logic sys_err,
   input wire logic lcl_err,
   input wire logic compute_only,
   input wire logic [5:0] lcl_addr,
   input wire logic [5:0] sys_addr,
   input wire logic [31:0] lcl_wdata,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe_n,
   input wire logic [31:0] pin_gpio,
   input wire logic [31:0] output_data_register
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire [31:0] o = output_data_register;
   wire w = lcl_sel && lcl_wr;
   wire s = sys_sel && !lcl_sel && !compute_only && !sys_err;
   wire [5:0] la = lcl_addr;
   set_bits_a: assert property (
      w && la == 6'h04 |=> o == ($past(o) | $past(lcl_wdata) & IMPL_MASK))
      else $error("set bad");
   clear_bits_a: assert property (
      w && la == 6'h08 |=> o == ($past(o) & ~$past(lcl_wdata)))
      else $error("clear bad");
   toggle_bits_a: assert property (
      w && la == 6'h0c |=> o == (($past(o) ^ $past(lcl_wdata)) & IMPL_MASK))
      else $error("toggle bad");
   pin_follow_a: assert property (pin_out == o) else $error("pin bad");
   oe_gpio_a: assert property (
      (~(pin_gpio & IMPL_MASK) & ~pin_oe_n) == 32'h0)
      else $error("oe bad");
   dma_stall_a: assert property (
      sys_sel && lcl_sel |-> !sys_ready)
      else $error("stall bad");
   compute_stall_a: assert property (
      sys_sel && compute_only |-> !sys_ready)
      else $error("compute bad");
   local_err_a: assert property (
      lcl_sel |=> lcl_err == ($past(la) > 6'h14 || ($past(la) & 6'h03) != 6'h00))
      else $error("lerr bad");
   sys_zero_wait_a: assert property (
      s && sys_addr <= 6'h14 && sys_addr[1:0] == 2'b00 |-> sys_ready)
      else $error("wait bad");
   sys_err_wait_a: assert property (
      s && sys_addr > 6'h14 |-> !sys_ready ##1 sys_err)
      else $error("serr bad");
endmodule : fgp_port_chk

// ==== verification/fgp_dma_model.sv ====
// Purpose: System bus master model
// Assumes: Ready sampled at the falling edge before the taking edge
// Notes: Released lines show inverted data
`timescale 1ns/1ns
module fgp_dma_model
   import fgp_pkg::*;
(
   input wire logic clk,
   input wire logic sys_ready,
   input wire logic sys_err,
   input wire logic [31:0] sys_rdata,
   output logic sys_sel = 0,
   output logic sys_wr = 0,
   output logic [5:0] sys_addr = 0,
   output logic [31:0] sys_wdata = 0
);
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      sys_sel <= 1; sys_wr <= w; sys_addr <= a; sys_wdata <= d;
      do @(negedge clk); while (!(sys_ready || sys_err) && ++n < 50);
      e = sys_err;
      @(posedge clk);
      sys_sel <= 0; sys_addr <= ~a; sys_wdata <= ~d;
      @(negedge clk);
      q = sys_rdata;
   endtask : xfer
endmodule : fgp_dma_model

// ==== verification/fgp_port_tb.sv ====
// Purpose: Bench for the fast port
// Assumes: 40 ns clock, upper pins absent
// Notes: Random writes over both ports
`timescale 1ns/1ns
module fgp_port_tb import fgp_pkg::*;;
   localparam logic [31:0] M = 32'h00ff_ffff;
   logic clk = 0, rst = 1, lcl_sel = 0, lcl_wr = 0, compute_only = 0, pctl_enable = 1;
   logic lcl_err, sys_sel, sys_wr, sys_ready, sys_err, e;
   logic [5:0] lcl_addr = 0, sys_addr;
   logic [31:0] lcl_wdata = 0, pin_digital = 0, pin_gpio = 0, pin_in = 0, om = 0, dm = 0, q;
   logic [31:0] lcl_rdata, sys_wdata, sys_rdata, pin_out, pin_oe_n, output_data_register;
   int bad_count = 0, num_checks = 0;
   fgp_port #(.IMPL_MASK(M)) fgp_port_i (.*);
   fgp_dma_model fgp_dma_model_i (.*);
   initial forever #20 clk = ~clk;
   initial begin
      #200000 bad_count++;
      final_report();
   end
   task automatic chk(input string n, input logic [31:0] s, x);
      num_checks++;
      if (s !== x) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic lcl(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      lcl_sel <= 1; lcl_wr <= w; lcl_addr <= a; lcl_wdata <= d;
      @(posedge clk);
      lcl_sel <= 0; lcl_wdata <= ~d;
      @(negedge clk);
      q = lcl_rdata;
      e = lcl_err;
   endtask : lcl
   function automatic logic [31:0] nxt(input logic [5:0] a, input logic [31:0] o, d);
      case (a)
         6'h00: return d & M;
         6'h04: return o | d & M;
         6'h08: return o & ~d;
         6'h0c: return (o ^ d) & M;
         default: return o;
      endcase
   endfunction : nxt
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   initial begin
      logic [5:0] a;
      logic [31:0] d;
      d = $urandom(32'h47b99c47);
      repeat (4) @(posedge clk);
      rst <= 0;
      for (int i = 0; i < 6; i++) begin
         lcl(0, 6'(i * 4), 0);
         chk("reset", q, 0);
      end
      $display("reset test done");
      repeat (60) begin
         a = 6'($urandom_range(5) * 4);
         d = $urandom;
         @(posedge clk);
         pin_gpio <= $urandom; pctl_enable <= 1'($urandom);
         if ($urandom_range(1)) lcl(1, a, d);
         else fgp_dma_model_i.xfer(1, a, d, q, e);
         if (a == 6'h14) dm = d & M;
         else om = nxt(a, om, d);
         lcl(0, 6'h00, 0);
         chk("out", q, om);
         lcl(0, 6'h14, 0);
         chk("dir", q, dm);
         chk("oe", pin_oe_n, ~(pin_gpio & dm));
         chk("pin", pin_out, om);
         fgp_dma_model_i.xfer(0, 6'h14, 0, q, e);
         chk("sysdir", q, dm);
         lcl(0, a, 0);
         if (a inside {6'h04, 6'h08, 6'h0c}) chk("wo", q, 0);
      end
      $display("random test done");
      lcl(1, 6'h18, 32'hffff_ffff);
      chk("lerr", {31'h0, e}, 1);
      fgp_dma_model_i.xfer(1, 6'h3c, 32'hffff_ffff, q, e);
      chk("serr", {31'h0, e}, 1);
      fork
         fgp_dma_model_i.xfer(1, 6'h04, 32'h0000_00f0, q, e);
         lcl(1, 6'h08, 32'h0000_00ff);
      join
      lcl(0, 6'h00, 0);
      chk("collide", q, om & ~32'hff | 32'hf0);
      $display("bus test done");
      @(posedge clk);
      pctl_enable <= 1; pin_digital <= 32'hffff_0f0f; pin_in <= $urandom;
      repeat (4) @(posedge clk);
      lcl(0, 6'h10, 0);
      chk("in", q, pin_in & pin_digital & M);
      d = q;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         pctl_enable <= k[0]; compute_only <= k[0]; pin_in <= ~pin_in;
         repeat (4) @(posedge clk);
         lcl(0, 6'h10, 0);
         chk("hold", q, d);
      end
      fork
         fgp_dma_model_i.xfer(1, 6'h14, 32'h5, q, e);
         begin repeat (3) @(posedge clk); compute_only <= 0; end
      join
      lcl(0, 6'h14, 0);
      chk("compute", q, 32'h5);
      $display("input test done");
      final_report();
   end
endmodule : fgp_port_tb
bind fgp_port fgp_port_chk #(.IMPL_MASK(IMPL_MASK)) fgp_port_chk_i (
   .clk(clk),
   .rst(rst),
   .lcl_sel(lcl_sel),
   .lcl_wr(lcl_wr),
   .sys_sel(sys_sel),
   .sys_ready(sys_ready),
   .sys_err(sys_err),
   .lcl_err(lcl_err),
   .compute_only(compute_only),
   .lcl_addr(lcl_addr),
   .sys_addr(sys_addr),
   .lcl_wdata(lcl_wdata),
   .pin_out(pin_out),
   .pin_oe_n(pin_oe_n),
   .pin_gpio(pin_gpio),
   .output_data_register(output_data_register)
);
